/* File: hw/tsp_port.sv */
// serial slave port and conversion control of the temperature sensor
`timescale 1ns/10ps
module tsp_port #(
   parameter int CONV_CYCLES = tsp_pkg::CONV_CYCLES_DFLT
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic serial_clock_in_i,
   input wire logic cs_n_i,
   input wire logic sio_i,
   output logic sio_o,
   output logic sio_oe_o,
   input wire logic [tsp_pkg::TEMP_W-1:0] temp_sample_i,
   output logic shutdown_o,
   output logic temp_valid_o
);
   import tsp_pkg::*;

   // ==========================================================
   // command decode, shared by full and partial receive phases
   // only 00 and FF act; any other byte leaves the mode alone (see RULE4)
   function automatic tsp_cmd_t decode_cmd(input logic [CMD_W-1:0] b);
      tsp_cmd_t c;
      c.apply = (b == CMD_CONV) || (b == CMD_SHDN);
      c.shutdown = (b == CMD_SHDN);
      return c;
   endfunction

   // ==========================================================
   // link domain: serial clock, frame ended by chip select
   logic lnk_rst;
   logic [CNT_W-1:0] rcnt_r;
   logic [CNT_W-1:0] rcnt_nxt;
   logic [CNT_W-1:0] fcnt_r;
   logic [CNT_W-1:0] fcnt_nxt;
   logic [CMD_W-1:0] rx_sh_r;
   logic [CMD_W-1:0] rx_sh_nxt;
   logic [CMD_W-1:0] cmd_r;
   logic [CMD_W-1:0] cmd_nxt;
   logic full_tg_r;
   logic full_tg_nxt;
   logic part_ok_r;
   logic part_ok_nxt;
   logic rx_phase;
   logic rx_last;
   logic [15:0] tx_word_r;

   // chip select high ends the frame without needing a clock edge
   assign lnk_rst = cs_n_i | sys_rst_i;

   // bit 4 of the rising count marks the receive half (see RULE14)
   assign rx_phase = rcnt_r[4];
   assign rx_last = (rcnt_r == CNT_LAST);
   assign rcnt_nxt = CNT_W'(rcnt_r + 1'b1);
   assign fcnt_nxt = CNT_W'(fcnt_r + 1'b1);

   // 8-bit window keeps only the latest bits (see RULE3)
   assign rx_sh_nxt = rx_phase ? {rx_sh_r[CMD_W-2:0], sio_i} : rx_sh_r;
   assign cmd_nxt = rx_last ? rx_sh_nxt : cmd_r;
   assign full_tg_nxt = rx_last ? ~full_tg_r : full_tg_r;
   // at least eight bits seen in an unfinished receive phase (see RULE18)
   assign part_ok_nxt = rx_phase && (rcnt_r[3:0] >= CMD_MIN_IDX) && !rx_last;

   // sampling on rising edges (see RULE15)
   always_ff @(posedge serial_clock_in_i or posedge lnk_rst) begin
      if (lnk_rst) begin
         rcnt_r <= '0;
      end else begin
         rcnt_r <= rcnt_nxt;
      end
   end

   // held past the frame so the system side can read them after chip select rises
   always_ff @(posedge serial_clock_in_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_sh_r <= '0;
         cmd_r <= '0;
         full_tg_r <= 1'b0;
         part_ok_r <= 1'b0;
      end else begin
         rx_sh_r <= rx_sh_nxt;
         cmd_r <= cmd_nxt;
         full_tg_r <= full_tg_nxt;
         part_ok_r <= part_ok_nxt;
      end
   end

   // output bit advances on falling edges (see RULE15)
   always_ff @(negedge serial_clock_in_i or posedge lnk_rst) begin
      if (lnk_rst) begin
         fcnt_r <= '0;
      end else begin
         fcnt_r <= fcnt_nxt;
      end
   end

   // msb first; first bit appears as soon as chip select falls (see RULE9)
   assign sio_o = tx_word_r[~fcnt_r[3:0]];
   // driven in every transmit half, released in receive halves (see RULE14)
   assign sio_oe_o = ~cs_n_i & ~fcnt_r[4];

   // ==========================================================
   // system domain: synchronisers
   logic [2:0] cs_sync_r;
   logic cs_q_r;
   logic cs_q_nxt;
   logic cs_rise_ev;
   logic [2:0] tg_sync_r;
   logic tg_q_r;
   logic tg_q_nxt;
   logic tg_ev;

   assign cs_q_nxt = (cs_sync_r[1] == cs_sync_r[2]) ? cs_sync_r[2] : cs_q_r;
   assign cs_rise_ev = ~cs_q_r & cs_q_nxt;
   assign tg_q_nxt = (tg_sync_r[1] == tg_sync_r[2]) ? tg_sync_r[2] : tg_q_r;
   assign tg_ev = tg_q_nxt ^ tg_q_r;

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cs_sync_r <= 3'h7;
         cs_q_r <= 1'b1;
         tg_sync_r <= 3'h0;
         tg_q_r <= 1'b0;
      end else begin
         cs_sync_r <= {cs_sync_r[1:0], cs_n_i};
         cs_q_r <= cs_q_nxt;
         tg_sync_r <= {tg_sync_r[1:0], full_tg_r};
         tg_q_r <= tg_q_nxt;
      end
   end

   // ==========================================================
   // system domain: mode, conversion and transmit word
   logic shutdown_r;
   logic shutdown_nxt;
   tsp_cmd_t cmd_full;
   tsp_cmd_t cmd_part;
   tsp_cmd_t cmd_sel;
   logic [CONV_CNT_W-1:0] conv_cnt_r;
   logic [CONV_CNT_W-1:0] conv_cnt_nxt;
   logic conv_done;
   logic publish;
   tsp_temp_word_t temp_word_r;
   tsp_temp_word_t temp_word_nxt;
   logic valid_r;
   logic valid_nxt;
   logic [15:0] tx_word_nxt;

   // link registers are quiet here: the toggle or the frame end proves them settled
   assign cmd_full = decode_cmd(cmd_r);
   assign cmd_part = decode_cmd(rx_sh_r);
   // a completed receive phase acts at its last clock so an id read can follow
   assign cmd_sel = tg_ev ? cmd_full : ((cs_rise_ev && part_ok_r) ? cmd_part : '0);   // see RULE3
   // 00 resumes conversion, xx FF shuts down; no path reads the mode back
   assign shutdown_nxt = cmd_sel.apply ? cmd_sel.shutdown : shutdown_r;   // see RULE1, see RULE2, see RULE13

   assign conv_done = (conv_cnt_r == CONV_CNT_W'(CONV_CYCLES - 1));
   // a finished conversion waits for the frame to close before publishing
   assign publish = conv_done && cs_q_r && !shutdown_r;   // see RULE17
   assign conv_cnt_nxt = shutdown_r ? '0 :
                         publish ? '0 :
                         conv_done ? conv_cnt_r :
                         CONV_CNT_W'(conv_cnt_r + 1'b1);   // see RULE6

   assign temp_word_nxt = publish ? tsp_temp_word_t'({temp_sample_i, LOW_ONES}) : temp_word_r;   // see RULE7, see RULE8
   // invalid from shutdown until the first fresh conversion
   assign valid_nxt = shutdown_r ? 1'b0 : (publish ? 1'b1 : valid_r);   // see RULE6
   // id replaces temperature while shut down; port keeps answering (see RULE10)
   assign tx_word_nxt = shutdown_r ? ID_WORD : temp_word_r;   // see RULE11, see RULE12

   // reset lands in continuous conversion (see RULE16)
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         shutdown_r <= 1'b0;
         conv_cnt_r <= '0;
         temp_word_r <= TEMP_RST;
         valid_r <= 1'b0;
         tx_word_r <= TEMP_RST;
      end else begin
         shutdown_r <= shutdown_nxt;
         conv_cnt_r <= conv_cnt_nxt;
         temp_word_r <= temp_word_nxt;
         valid_r <= valid_nxt;
         tx_word_r <= tx_word_nxt;
      end
   end

   assign shutdown_o = shutdown_r;
   assign temp_valid_o = valid_r;

endmodule

/* File: common/tsp_pkg.sv */
// constants, types and field layouts of the temperature sensor serial port
// Function
// RULE1: received command byte 00 selects continuous conversion mode.
// RULE2: received low byte FF selects shutdown; upper eight command bits are ignored.
// RULE3: only the last eight bits shifted in before chip select rises count.
// RULE4: host sends only 00 or FF; other codes are not honoured.
// RULE5: host may read, shut down, read identification, resume, all in one access.
// RULE6: temperature is valid only after a 300 ms conversion following shutdown exit.
// RULE7: temperature is 14-bit two's complement in bits 15..2, 0.03125 C steps.
// RULE8: temperature word bits 1 and 0 always read as one.
// RULE9: words shift out most significant bit first.
// RULE10: serial interface stays fully working while shut down.
// RULE11: in shutdown a fixed identification word with low bits one is sent.
// RULE12: identification word replaces temperature in every transmit phase during shutdown.
// RULE13: temperature and identification are read-only; mode word has no readback.
// RULE14: an access is 32 clocks: 16 transmit then 16 receive.
// RULE15: device drives data on falling edges and samples on rising edges.
// RULE16: reset leaves the device in continuous conversion mode.
// RULE17: reads never disturb a conversion; results publish after the access ends.
// RULE18: a partial command takes effect when chip select rises.
package tsp_pkg;

   // ==========================================================
   // serial framing
   localparam int PHASE_BITS = 16;
   localparam int CNT_W = 5;
   localparam int CMD_W = 8;
   localparam logic [CNT_W-1:0] CNT_LAST = 5'h1F;
   localparam logic [3:0] CMD_MIN_IDX = 4'h7;

   // ==========================================================
   // command codes
   localparam logic [CMD_W-1:0] CMD_CONV = 8'h00;
   localparam logic [CMD_W-1:0] CMD_SHDN = 8'hFF;

   // ==========================================================
   // word layouts and reset values
   localparam int TEMP_W = 14;
   localparam logic [1:0] LOW_ONES = 2'h3;
   localparam logic [15:0] TEMP_RST = 16'h0003;
   // identification word: value arbitrary, top five bits are the maker field
   localparam logic [15:0] ID_WORD = 16'h5003;

   // ==========================================================
   // conversion timing
   localparam int CONV_TIME_MS = 300;
   localparam int SYS_CLK_MHZ = 100;
   localparam int CONV_CYCLES_DFLT = CONV_TIME_MS * 1000 * 1000 / 1000 * SYS_CLK_MHZ;
   localparam int CONV_CNT_W = 25;

   // ==========================================================
   // types
   typedef struct packed {
      logic [TEMP_W-1:0] temp;
      logic [1:0] ones;
   } tsp_temp_word_t;

   typedef struct packed {
      logic apply;
      logic shutdown;
   } tsp_cmd_t;

endpackage

/* File: tb/tsp_port_monitor.sv */
// checker of link framing and mode flags of the serial port
`timescale 1ns/10ps
module tsp_port_monitor #(
   parameter int CONV_CYCLES = 50
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic serial_clock_in_i,
   input wire logic cs_n_i,
   input wire logic sio_o,
   input wire logic sio_oe_o,
   input wire logic shutdown_o,
   input wire logic temp_valid_o
);
   // ========
   // helper counts
   logic [4:0] rise_r;
   logic [31:0] run_r;
   logic [3:0] idle_r;
   always_ff @(posedge serial_clock_in_i or posedge cs_n_i) begin
      if (cs_n_i) rise_r <= 5'h00;
      else rise_r <= rise_r + 5'h01;
   end
   // counts running cycles since reset or shutdown exit
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) run_r <= 32'h0;
      else if (shutdown_o) run_r <= 32'h0;
      else if (run_r < CONV_CYCLES) run_r <= run_r + 32'h1;
   end
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) idle_r <= 4'h0;
      else if (!cs_n_i) idle_r <= 4'h0;
      else if (idle_r != 4'hF) idle_r <= idle_r + 4'h1;
   end
   // ========
   // properties
   sequence s_tx_half;
      rise_r < 5'h10;
   endsequence
   a_oe_tx_half: assert property (@(posedge serial_clock_in_i) disable iff (sys_rst_i || cs_n_i)
      s_tx_half |-> sio_oe_o) else $error("oe low in transmit half");
   a_oe_rx_half: assert property (@(posedge serial_clock_in_i) disable iff (sys_rst_i || cs_n_i)
      rise_r >= 5'h10 |-> !sio_oe_o) else $error("oe high in receive half");
   a_low_bits_one: assert property (@(posedge serial_clock_in_i) disable iff (sys_rst_i || cs_n_i)
      (rise_r == 5'h0E || rise_r == 5'h0F) |-> sio_o) else $error("low word bit not one");
   a_idle_no_drive: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      cs_n_i |-> !sio_oe_o) else $error("data driven while deselected");
   a_valid_after_conv: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      $rose(temp_valid_o) |-> !shutdown_o && run_r >= CONV_CYCLES - 1) else $error("valid too early");
   a_no_valid_shdn: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      shutdown_o && $past(shutdown_o) |-> !temp_valid_o) else $error("valid during shutdown");
   a_valid_holds: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      $fell(temp_valid_o) |-> shutdown_o) else $error("valid dropped while running");
   a_mode_at_cs: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      idle_r >= 4'h8 |-> $stable(shutdown_o)) else $error("mode changed long after deselect");
endmodule
bind tsp_port tsp_port_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon (.clk_sys_i(clk_sys_i),
   .sys_rst_i(sys_rst_i), .serial_clock_in_i(serial_clock_in_i), .cs_n_i(cs_n_i), .sio_o(sio_o),
   .sio_oe_o(sio_oe_o), .shutdown_o(shutdown_o), .temp_valid_o(temp_valid_o));

/* File: tb/tsp_host_model.sv */
// host master model driving serial clock, select and data
`timescale 1ns/10ps
module tsp_host_model (
   input wire logic clk_link_i,
   input wire logic sio_pin_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   output logic mosi_oe_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
      mosi_oe_o = 1'b0;
   end
   // ========
   // framing, clock stands still outside frames
   task start;
      @(posedge clk_link_i);
      cs_n_o = 1'b0;
      repeat (10) @(posedge clk_link_i);
   endtask
   task word(input logic [15:0] w, input int n, input logic drv, output logic [15:0] q);
      q = 16'h0000;
      for (int i = 0; i < n; i++) begin
         // 84 ns per half period keeps the serial clock above its 160 ns minimum
         @(posedge clk_link_i);
         mosi_o = w[15-i];
         mosi_oe_o = drv;
         repeat (6) @(posedge clk_link_i);
         sclk_o = 1'b1;
         q = {q[14:0], sio_pin_i};
         // stretched high gives the mode change time before the next word
         if (drv && i == 15) repeat (12) @(posedge clk_link_i);
         repeat (7) @(posedge clk_link_i);
         if (i == n - 1) mosi_oe_o = 1'b0;
         sclk_o = 1'b0;
      end
   endtask
   task stop;
      @(posedge clk_link_i);
      cs_n_o = 1'b1;
      repeat (4) @(posedge clk_link_i);
   endtask
endmodule

/* File: tb/tsp_port_tb_top.sv */
// testbench of the temperature sensor serial port
`timescale 1ns/10ps
module tsp_port_tb_top;
   import tsp_pkg::*;
   localparam int CONV = 50;
   logic clk_sys_i = 1'b0;
   logic clk_link = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [TEMP_W-1:0] temp_sample_i = 14'h0320;
   logic sclk, cs_n, mosi, mosi_oe, sio_o, sio_oe_o, shutdown_o, temp_valid_o;
   logic last_r = 1'b0;
   int n_errors = 0;
   int comparisons = 0;
   // released line shows the inverse of its last level
   wire sio_pin = sio_oe_o ? sio_o : (mosi_oe ? mosi : ~last_r);
   always #5 clk_sys_i = ~clk_sys_i;
   always #6 clk_link = ~clk_link;
   always @(posedge clk_link) if (sio_oe_o === 1'b1 || mosi_oe) last_r <= sio_pin;
   always @(negedge clk_link) if (sio_oe_o !== 1'b0 && mosi_oe) cmp("sio contention", 16'h0, 16'h1);
   tsp_port #(.CONV_CYCLES(CONV)) DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .serial_clock_in_i(sclk),
      .cs_n_i(cs_n), .sio_i(sio_pin), .sio_o(sio_o), .sio_oe_o(sio_oe_o), .temp_sample_i(temp_sample_i),
      .shutdown_o(shutdown_o), .temp_valid_o(temp_valid_o));
   tsp_host_model host (.clk_link_i(clk_link), .sio_pin_i(sio_pin), .sclk_o(sclk), .cs_n_o(cs_n),
      .mosi_o(mosi), .mosi_oe_o(mosi_oe));
   // ========
   // tasks
   task cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task acc(input logic [15:0] w, input int n, output logic [15:0] q);
      logic [15:0] j;
      host.start();
      host.word(16'h0000, 16, 1'b0, q);
      host.word(w, n, 1'b1, j);
      host.stop();
      repeat (10) @(negedge clk_sys_i);
   endtask
   task wait_valid;
      int i;
      for (i = 0; i < 400 && temp_valid_o !== 1'b1; i++) @(negedge clk_sys_i);
      if (i == 400) begin
         n_errors++;
         tally_and_finish();
      end
   endtask
   task tally_and_finish;
      if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ========
   // scenarios
   initial begin
      logic [15:0] q;
      logic [15:0] j;
      repeat (8) @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
      cmp("shutdown", 16'h0, shutdown_o);
      cmp("valid", 16'h0, temp_valid_o);
      wait_valid();
      acc(16'h0000, 16, q);
      cmp("temp", 16'h0C83, q);
      host.start();
      @(negedge clk_sys_i);
      temp_sample_i = 14'h3FFF;
      repeat (CONV + 20) @(negedge clk_sys_i);
      host.word(16'h0000, 4, 1'b0, q);
      cmp("lead bits", 16'h0000, q);
      host.stop();
      repeat (10) @(negedge clk_sys_i);
      host.start();
      host.word(16'h0000, 16, 1'b0, q);
      cmp("refreshed", 16'hFFFF, q);
      host.word(16'hFFFF, 16, 1'b1, j);
      host.word(16'h0000, 16, 1'b0, q);
      cmp("id", ID_WORD, q);
      cmp("shutdown", 16'h1, shutdown_o);
      host.word(16'h0000, 8, 1'b1, j);
      host.stop();
      repeat (10) @(negedge clk_sys_i);
      cmp("resumed", 16'h0, shutdown_o);
      cmp("valid", 16'h0, temp_valid_o);
      wait_valid();
      acc(16'hA5FF, 16, q);
      cmp("shutdown", 16'h1, shutdown_o);
      acc(16'h005A, 16, q);
      cmp("id", ID_WORD, q);
      cmp("shutdown", 16'h1, shutdown_o);
      acc(16'hF000, 12, q);
      cmp("id", ID_WORD, q);
      cmp("resumed", 16'h0, shutdown_o);
      tally_and_finish();
   end
endmodule
